// ===== core/flash_space_select_and_program_launch.sv
// Flash space select, programming launch, auxiliary register and dual data pointers.
// How it works
// - Two 16-bit data pointers exist and bit 0 of the auxiliary register picks the second one when set.
// - Bit 2 of the auxiliary register always reads zero so an increment toggles only the pointer select.
// - The boot map bit puts the boot array at code addresses from F800h upward, otherwise user flash.
// - Reset loads the boot map bit from the boot jump fuse and clears the pointer select and bit 2.
// - The two space select bits choose user, extra row, security or a reserved view of code space.
// - A code space data read returns data from the space that the select bits name; an instruction fetch always reads the user space.
// - Programming starts only when 5 and then A are written to the launch key field.
// - A completed key writes the latches to user space for 00 and to the extra row for 01.
// - A completed key writes the fuse byte for 10, does nothing for 11, and ignores the page bit.
// - Once launched the flash is busy at once and serves no fetch until the write ends.
// - The core is held idle while programming and released automatically at the end.
// - The busy bit of the flash control register reads one while programming runs.
`timescale 1ns/1ps
`default_nettype none
module flash_space_select_and_program_launch #(
    parameter int USER_AW     = 16,
    parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
    input  wire logic                             CLOCK,
    input  wire logic                             RST_N,
    input  wire logic [flash_seq_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                             AVS_READ,
    input  wire logic                             AVS_WRITE,
    input  wire logic [31:0]                      AVS_WRITEDATA,
    input  wire logic [3:0]                       AVS_BYTEENABLE,
    output logic      [31:0]                      AVS_READDATA,
    output logic                                  AVS_WAITREQUEST,
    output logic                                  IRQ,
    input  wire logic                             BOOT_JUMP_FUSE,
    input  wire logic                             CODE_RD_REQ,
    input  wire logic                             CODE_RD_IS_DATA,
    input  wire logic [15:0]                      CODE_RD_ADDR,
    output logic      [7:0]                       CODE_RD_DATA,
    output logic                                  CODE_RD_VALID,
    output logic                                  CORE_IDLE,
    output logic      [15:0]                      ACTIVE_DPTR
);
    typedef struct packed {
        logic                                  wait_n;
        logic [31:0]                           rdata;
        logic                                  irq;
        logic                                  ptr_sel;
        logic                                  user_flag;
        logic                                  boot_map;
        logic [15:0]                           dp0;
        logic [15:0]                           dp1;
        logic [1:0]                            space;
        logic                                  page;
        logic                                  armed;
        logic                                  busy;
        logic [flash_seq_pkg::PROG_CNT_W-1:0]  cnt;
        logic [1:0]                            prog_space;
        logic [15:0]                           latch_addr;
        logic [7:0]                            latch_data;
        logic [7:0]                            security;
        logic [flash_seq_pkg::IRQ_W-1:0]       sts;
        logic [flash_seq_pkg::IRQ_W-1:0]       mask;
        logic [7:0]                            code_data;
        logic                                  code_valid;
        logic [15:0]                           adptr;
    } state_s;

    localparam logic [flash_seq_pkg::ADDR_W-1:0] AUX_A    = {flash_seq_pkg::AUX_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] DP0_LO_A = {flash_seq_pkg::DP0_LO_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] DP0_HI_A = {flash_seq_pkg::DP0_HI_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] DP1_LO_A = {flash_seq_pkg::DP1_LO_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] DP1_HI_A = {flash_seq_pkg::DP1_HI_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] FCTRL_A  = {flash_seq_pkg::FCTRL_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] LA_LO_A  = {flash_seq_pkg::LADDR_LO_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] LA_HI_A  = {flash_seq_pkg::LADDR_HI_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] LDATA_A  = {flash_seq_pkg::LDATA_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] STS_A    = {flash_seq_pkg::IRQ_STS_IDX, 2'b00};
    localparam logic [flash_seq_pkg::ADDR_W-1:0] MASK_A   = {flash_seq_pkg::IRQ_MASK_IDX, 2'b00};
    localparam logic [flash_seq_pkg::PROG_CNT_W-1:0] PROG_LOAD = flash_seq_pkg::PROG_CNT_W'(PROG_CYCLES);
    localparam logic [flash_seq_pkg::PROG_CNT_W-1:0] CNT_ONE   = flash_seq_pkg::PROG_CNT_W'(1);

    logic [7:0] user_mem  [2**USER_AW];
    logic [7:0] boot_mem  [2**flash_seq_pkg::BOOT_AW];
    logic [7:0] extra_mem [2**flash_seq_pkg::EXTRA_AW];

    state_s s;
    state_s nxt;
    logic   prog_commit;
    logic   boot_hit_prog;

    // Bus request is taken on the edge where waitrequest is seen low.
    logic req;
    logic wr_take;
    assign req     = AVS_READ | AVS_WRITE;
    assign wr_take = AVS_WRITE & ~s.wait_n & AVS_BYTEENABLE[0];

    // The memory array write lands on the last cycle of the programming time.
    assign prog_commit   = s.busy & (s.cnt == CNT_ONE);
    assign boot_hit_prog = s.boot_map & (s.latch_addr >= flash_seq_pkg::BOOT_BASE);

    always_comb begin
        logic [7:0]  wb;
        logic [7:0]  rd;
        logic [7:0]  cb;
        logic [15:0] ca;
        logic [1:0]  sv;
        wb = AVS_WRITEDATA[7:0];
        rd = 8'h00;
        cb = flash_seq_pkg::BLANK_BYTE;
        ca = CODE_RD_ADDR;
        sv = CODE_RD_IS_DATA ? s.space : flash_seq_pkg::SPACE_USER;
        nxt = s;

        // Register read mux; reserved auxiliary bits read as zero.
        unique case (AVS_ADDRESS)
            AUX_A: begin
                rd[flash_seq_pkg::AUX_PTR_SEL_BIT]  = s.ptr_sel;
                rd[flash_seq_pkg::AUX_FLAG_BIT]     = s.user_flag;
                rd[flash_seq_pkg::AUX_BOOT_MAP_BIT] = s.boot_map;
                rd[flash_seq_pkg::AUX_ZERO_BIT]     = 1'b0;
            end
            DP0_LO_A: rd = s.dp0[7:0];
            DP0_HI_A: rd = s.dp0[15:8];
            DP1_LO_A: rd = s.dp1[7:0];
            DP1_HI_A: rd = s.dp1[15:8];
            FCTRL_A: begin
                rd[flash_seq_pkg::FC_BUSY_BIT] = s.busy;
                rd[flash_seq_pkg::FC_SPACE_LSB +: 2] = s.space;
                rd[flash_seq_pkg::FC_PAGE_BIT] = s.page;
            end
            LA_LO_A:  rd = s.latch_addr[7:0];
            LA_HI_A:  rd = s.latch_addr[15:8];
            LDATA_A:  rd = s.latch_data;
            STS_A:    rd = {6'h00, s.sts};
            MASK_A:   rd = {6'h00, s.mask};
            default:  rd = 8'h00;
        endcase

        // One wait cycle on every access, then a single ready cycle.
        nxt.wait_n = ~(req & s.wait_n);
        if (req & s.wait_n) begin
            nxt.rdata = {24'h000000, rd};
        end

        if (prog_commit) begin
            nxt.busy = 1'b0;
            nxt.sts[flash_seq_pkg::IRQ_DONE_BIT] = 1'b1;
            if (s.prog_space == flash_seq_pkg::SPACE_SECURITY) begin
                nxt.security = s.latch_data;
            end
        end else if (s.busy) begin
            nxt.cnt = s.cnt - CNT_ONE;
        end

        if (wr_take) begin
            unique case (AVS_ADDRESS)
                AUX_A: begin
                    nxt.ptr_sel   = wb[flash_seq_pkg::AUX_PTR_SEL_BIT];
                    nxt.user_flag = wb[flash_seq_pkg::AUX_FLAG_BIT];
                    nxt.boot_map  = wb[flash_seq_pkg::AUX_BOOT_MAP_BIT];
                end
                DP0_LO_A: nxt.dp0[7:0]  = wb;
                DP0_HI_A: nxt.dp0[15:8] = wb;
                DP1_LO_A: nxt.dp1[7:0]  = wb;
                DP1_HI_A: nxt.dp1[15:8] = wb;
                FCTRL_A: begin
                    nxt.space = wb[flash_seq_pkg::FC_SPACE_LSB +: 2];
                    nxt.page  = wb[flash_seq_pkg::FC_PAGE_BIT];
                    nxt.armed = 1'b0;
                    if (wb[flash_seq_pkg::FC_KEY_LSB +: 4] == flash_seq_pkg::KEY_ARM) begin
                        nxt.armed = 1'b1;
                    end else if (wb[flash_seq_pkg::FC_KEY_LSB +: 4] == flash_seq_pkg::KEY_LAUNCH) begin
                        // The page bit plays no part in the launch decision.
                        if (s.armed && !s.busy && nxt.space != flash_seq_pkg::SPACE_RESERVED) begin
                            nxt.busy       = 1'b1;
                            nxt.cnt        = PROG_LOAD;
                            nxt.prog_space = nxt.space;
                        end
                    end else if (s.armed) begin
                        nxt.sts[flash_seq_pkg::IRQ_ABORT_BIT] = 1'b1;
                    end
                end
                LA_LO_A:  nxt.latch_addr[7:0]  = wb;
                LA_HI_A:  nxt.latch_addr[15:8] = wb;
                LDATA_A:  nxt.latch_data = wb;
                // Clearing by writing one; a same-cycle hardware set wins.
                STS_A:    nxt.sts  = nxt.sts & ~(wb[flash_seq_pkg::IRQ_W-1:0] & ~(nxt.sts ^ s.sts));
                MASK_A:   nxt.mask = wb[flash_seq_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end

        // Code space view for fetches and data reads.
        unique case (sv)
            flash_seq_pkg::SPACE_USER: begin
                if (s.boot_map && ca >= flash_seq_pkg::BOOT_BASE) begin
                    cb = boot_mem[ca[flash_seq_pkg::BOOT_AW-1:0]];
                end else begin
                    cb = user_mem[ca[USER_AW-1:0]];
                end
            end
            flash_seq_pkg::SPACE_EXTRA: begin
                if (ca >= flash_seq_pkg::EXTRA_BASE) begin
                    cb = extra_mem[ca[flash_seq_pkg::EXTRA_AW-1:0]];
                end
            end
            flash_seq_pkg::SPACE_SECURITY: begin
                if (ca == 16'h0000) begin
                    cb = s.security;
                end
            end
            flash_seq_pkg::SPACE_RESERVED: cb = flash_seq_pkg::BLANK_BYTE;
        endcase

        // No read is served while the array is busy programming.
        nxt.code_valid = CODE_RD_REQ & ~nxt.busy;
        if (nxt.code_valid) begin
            nxt.code_data = cb;
        end

        nxt.irq   = |(nxt.sts & nxt.mask);
        nxt.adptr = nxt.ptr_sel ? nxt.dp1 : nxt.dp0;

        if (!RST_N) begin
            nxt             = '0;
            nxt.wait_n      = 1'b1;
            nxt.security    = flash_seq_pkg::SECURITY_RESET;
            nxt.boot_map    = BOOT_JUMP_FUSE;
            nxt.ptr_sel     = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        s <= nxt;
    end

    always_ff @(posedge CLOCK) begin
        if (prog_commit) begin
            unique case (s.prog_space)
                flash_seq_pkg::SPACE_USER: begin
                    if (boot_hit_prog) begin
                        boot_mem[s.latch_addr[flash_seq_pkg::BOOT_AW-1:0]] <= s.latch_data;
                    end else begin
                        user_mem[s.latch_addr[USER_AW-1:0]] <= s.latch_data;
                    end
                end
                flash_seq_pkg::SPACE_EXTRA: extra_mem[s.latch_addr[flash_seq_pkg::EXTRA_AW-1:0]] <= s.latch_data;
                default: ;
            endcase
        end
    end

    // Busy doubles as the idle hold, so release and the done status set share one edge.
    assign CORE_IDLE       = s.busy;
    assign AVS_READDATA    = s.rdata;
    assign AVS_WAITREQUEST = s.wait_n;
    assign IRQ             = s.irq;
    assign CODE_RD_DATA    = s.code_data;
    assign CODE_RD_VALID   = s.code_valid;
    assign ACTIVE_DPTR     = s.adptr;

    default clocking cb_main @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_dptr_follows_sel: assert property (ACTIVE_DPTR == (s.ptr_sel ? s.dp1 : s.dp0))
        else $error("Active pointer does not follow the select bit.");
    a_aux_bit_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == AUX_A
        |-> AVS_READDATA[flash_seq_pkg::AUX_ZERO_BIT] == 1'b0 && AVS_READDATA[0] == s.ptr_sel)
        else $error("Auxiliary read shows bit 2 set or a wrong select bit.");
    a_reset_loads_fuse: assert property ($rose(RST_N)
        |-> s.boot_map == $past(BOOT_JUMP_FUSE) && !s.ptr_sel && !s.busy)
        else $error("Reset did not load the boot map from the fuse.");
    a_key_launches: assert property (wr_take && AVS_ADDRESS == FCTRL_A && s.armed && !s.busy
        && AVS_WRITEDATA[7:4] == flash_seq_pkg::KEY_LAUNCH && AVS_WRITEDATA[2:1] != flash_seq_pkg::SPACE_RESERVED
        |=> CORE_IDLE && s.prog_space == $past(AVS_WRITEDATA[2:1]))
        else $error("Completed key did not launch programming.");
    a_arm_alone_idle: assert property (wr_take && AVS_ADDRESS == FCTRL_A && !s.busy
        && AVS_WRITEDATA[7:4] == flash_seq_pkg::KEY_ARM |=> !s.busy ##1 !s.busy)
        else $error("Writing the arm value alone started programming.");
    a_reserved_space_noop: assert property (wr_take && AVS_ADDRESS == FCTRL_A && !s.busy
        && AVS_WRITEDATA[2:1] == flash_seq_pkg::SPACE_RESERVED |=> !s.busy)
        else $error("Reserved space started programming.");
    a_busy_stays: assert property ($rose(s.busy) |-> s.busy[*8])
        else $error("Busy dropped before the programming time.");
    a_no_fetch_busy: assert property (CORE_IDLE |-> !CODE_RD_VALID)
        else $error("Code read served while programming.");
    a_busy_readback: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == FCTRL_A
        |-> AVS_READDATA[0] == $past(s.busy))
        else $error("Busy bit read back wrong.");
    a_done_releases: assert property ($fell(CORE_IDLE)
        |-> !s.busy && s.sts[flash_seq_pkg::IRQ_DONE_BIT] && $past(s.cnt) == CNT_ONE)
        else $error("Idle release and completion are out of step.");
    a_wrong_key_drops: assert property (wr_take && AVS_ADDRESS == FCTRL_A && s.armed
        && AVS_WRITEDATA[7:4] != flash_seq_pkg::KEY_ARM |=> !s.armed)
        else $error("Armed key survived a wrong value.");
    a_extra_row_blank: assert property (CODE_RD_REQ && CODE_RD_IS_DATA && !nxt.busy
        && s.space == flash_seq_pkg::SPACE_EXTRA && CODE_RD_ADDR < flash_seq_pkg::EXTRA_BASE
        |=> CODE_RD_VALID && CODE_RD_DATA == flash_seq_pkg::BLANK_BYTE)
        else $error("Extra row view returned data outside its range.");

    // The checks below pin down the cycle-level promises that software and the core lean on.
    // A write that lands one cycle late would still pass the bench, so these look at every edge.
    a_flag_written: assert property (wr_take && AVS_ADDRESS == AUX_A
        |=> s.user_flag == $past(AVS_WRITEDATA[flash_seq_pkg::AUX_FLAG_BIT]))
        else $error("General flag did not take the written value.");
    a_reserved_view: assert property (CODE_RD_REQ && CODE_RD_IS_DATA && !nxt.busy
        && s.space == flash_seq_pkg::SPACE_RESERVED |=> CODE_RD_VALID && CODE_RD_DATA == flash_seq_pkg::BLANK_BYTE)
        else $error("Reserved view returned something other than blank.");
    a_security_view: assert property (CODE_RD_REQ && CODE_RD_IS_DATA && !nxt.busy
        && s.space == flash_seq_pkg::SPACE_SECURITY && CODE_RD_ADDR == 16'h0000
        |=> CODE_RD_VALID && CODE_RD_DATA == $past(s.security))
        else $error("Security view did not return the fuse byte.");
    a_extra_served: assert property (CODE_RD_REQ && CODE_RD_IS_DATA && !nxt.busy
        && s.space == flash_seq_pkg::SPACE_EXTRA && CODE_RD_ADDR >= flash_seq_pkg::EXTRA_BASE |=> CODE_RD_VALID)
        else $error("Extra row read was not served.");
    a_arm_sets: assert property (wr_take && AVS_ADDRESS == FCTRL_A
        && AVS_WRITEDATA[flash_seq_pkg::FC_KEY_LSB +: 4] == flash_seq_pkg::KEY_ARM |=> s.armed)
        else $error("Arm value did not arm the launch key.");
    a_unarmed_key: assert property (wr_take && AVS_ADDRESS == FCTRL_A && !s.armed && !s.busy
        |=> !s.busy)
        else $error("Programming started without an armed key.");
    a_fuse_written: assert property (prog_commit && s.prog_space == flash_seq_pkg::SPACE_SECURITY
        |=> s.security == $past(s.latch_data))
        else $error("Fuse byte was not written at completion.");
    a_busy_counts: assert property (CORE_IDLE && s.cnt != CNT_ONE
        |=> CORE_IDLE && s.cnt == $past(s.cnt) - CNT_ONE)
        else $error("Programming time counter did not step down.");
    a_idle_release: assert property (CORE_IDLE && s.cnt == CNT_ONE |=> !CORE_IDLE)
        else $error("Core was not released when programming ended.");
    a_done_status: assert property (prog_commit |=> !s.busy && s.sts[flash_seq_pkg::IRQ_DONE_BIT])
        else $error("Busy and done status out of step at completion.");
    a_abort_flag: assert property (wr_take && AVS_ADDRESS == FCTRL_A && s.armed
        && AVS_WRITEDATA[flash_seq_pkg::FC_KEY_LSB +: 4] != flash_seq_pkg::KEY_ARM
        && AVS_WRITEDATA[flash_seq_pkg::FC_KEY_LSB +: 4] != flash_seq_pkg::KEY_LAUNCH
        |=> s.sts[flash_seq_pkg::IRQ_ABORT_BIT])
        else $error("Broken key sequence did not raise the abort status.");
endmodule
`default_nettype wire

// ===== pkg/flash_seq_pkg.sv
// Constants shared by the flash space select and programming launch block.
package flash_seq_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] AUX_IDX        = 8'hA2;
    localparam logic [7:0] DP0_LO_IDX     = 8'h82;
    localparam logic [7:0] DP0_HI_IDX     = 8'h83;
    localparam logic [7:0] DP1_LO_IDX     = 8'h84;
    localparam logic [7:0] DP1_HI_IDX     = 8'h85;
    localparam logic [7:0] FCTRL_IDX      = 8'hD1;
    localparam logic [7:0] LADDR_LO_IDX   = 8'hD2;
    localparam logic [7:0] LADDR_HI_IDX   = 8'hD3;
    localparam logic [7:0] LDATA_IDX      = 8'hD4;
    localparam logic [7:0] IRQ_STS_IDX    = 8'hD5;
    localparam logic [7:0] IRQ_MASK_IDX   = 8'hD6;
    localparam int         ADDR_W         = 10;

    // Auxiliary register fields.
    localparam int AUX_PTR_SEL_BIT  = 0;
    localparam int AUX_ZERO_BIT     = 2;
    localparam int AUX_FLAG_BIT     = 3;
    localparam int AUX_BOOT_MAP_BIT = 5;

    // Flash control register fields.
    localparam int FC_BUSY_BIT  = 0;
    localparam int FC_SPACE_LSB = 1;
    localparam int FC_PAGE_BIT  = 3;
    localparam int FC_KEY_LSB   = 4;

    // Launch key values.
    localparam logic [3:0] KEY_ARM    = 4'h5;
    localparam logic [3:0] KEY_LAUNCH = 4'hA;

    // Space select codes.
    localparam logic [1:0] SPACE_USER     = 2'h0;
    localparam logic [1:0] SPACE_EXTRA    = 2'h1;
    localparam logic [1:0] SPACE_SECURITY = 2'h2;
    localparam logic [1:0] SPACE_RESERVED = 2'h3;

    // Code map boundaries and filler for unselected addresses.
    localparam logic [15:0] BOOT_BASE  = 16'hF800;
    localparam logic [15:0] EXTRA_BASE = 16'hFF80;
    localparam logic [7:0]  BLANK_BYTE = 8'hFF;
    localparam int          BOOT_AW    = 11;
    localparam int          EXTRA_AW   = 7;

    // Interrupt status bits.
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_W         = 2;

    // Reset values.
    localparam logic [7:0] SECURITY_RESET = 8'hFF;

    // Programming time and its cycle count at the core clock.
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS  = 10000;
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W    = 16;
endpackage

// ===== verif/core_model.sv
// Behavioural processor core that issues code space reads to the flash block.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clock,
    input  wire logic        idle,
    output logic             req,
    output logic             is_data,
    output logic [15:0]      addr
);
    initial begin
        req = 1'b0;
        is_data = 1'b0;
        addr = 16'h0000;
    end

    // Interrupts stay off in this core, so an idle core issues nothing until programming ends.
    task fetch(input logic [15:0] a, input logic d);
        int n;
        n = 0;
        while (idle !== 1'b0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        @(posedge clock);
        req <= 1'b1;
        addr <= a;
        is_data <= d;
        @(posedge clock);
        req <= 1'b0;
        // A released address shows the inverse so a stale value never looks valid.
        addr <= ~a;
        is_data <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== verif/flash_space_select_and_program_launch_test.sv
// Self-checking testbench for the flash space select and programming launch block.
`timescale 1ns/1ps
`default_nettype none
module flash_space_select_and_program_launch_test;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic        fuse = 1'b1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        rd_req;
    logic        rd_is_data;
    logic [15:0] rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        core_idle;
    logic [15:0] active_dptr;
    logic [31:0] rq[$];
    logic [7:0]  cq[$];
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [15:0] p0;
    logic [15:0] p1;
    int          n_errors = 0;
    int          check_count = 0;
    int          seed = 30401;

    always #2 clock = ~clock;

    flash_space_select_and_program_launch #(.PROG_CYCLES(10)) flash_space_select_and_program_launch_inst (
        .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
        .BOOT_JUMP_FUSE(fuse), .CODE_RD_REQ(rd_req), .CODE_RD_IS_DATA(rd_is_data),
        .CODE_RD_ADDR(rd_addr), .CODE_RD_DATA(rd_data), .CODE_RD_VALID(rd_valid),
        .CORE_IDLE(core_idle), .ACTIVE_DPTR(active_dptr));

    core_model core_model_inst (.clock(clock), .idle(core_idle), .req(rd_req), .is_data(rd_is_data),
        .addr(rd_addr));

    task cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR at %0t got %0h expected %0h", $time, g, e);
        end
    endtask

    task conclude;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] e);
        rq.push_back({24'h000000, e});
        bus(1'b0, idx, 8'h00);
    endtask

    task key(input logic [1:0] sp, input logic [3:0] k);
        bus(1'b1, flash_seq_pkg::FCTRL_IDX, {k, 1'b1, sp, 1'b0});
    endtask

    task cf(input logic [15:0] a, input logic isd, input logic [7:0] e);
        cq.push_back(e);
        core_model_inst.fetch(a, isd);
        repeat (2) @(posedge clock);
    endtask

    // The page bit is always set here since it must not change what gets programmed.
    task prog(input logic [1:0] sp, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        bus(1'b1, flash_seq_pkg::LADDR_LO_IDX, a[7:0]);
        bus(1'b1, flash_seq_pkg::LADDR_HI_IDX, a[15:8]);
        bus(1'b1, flash_seq_pkg::LDATA_IDX, d);
        key(sp, flash_seq_pkg::KEY_ARM);
        key(sp, flash_seq_pkg::KEY_LAUNCH);
        @(posedge clock);
        cmp(core_idle, 32'h1);
        rd(flash_seq_pkg::FCTRL_IDX, {4'h0, 1'b1, sp, 1'b1});
        while (core_idle !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        rd(flash_seq_pkg::FCTRL_IDX, {4'h0, 1'b1, sp, 1'b0});
        cmp(irq, 32'h1);
        bus(1'b1, flash_seq_pkg::IRQ_STS_IDX, 8'h01);
        repeat (2) @(posedge clock);
        cmp(irq, 32'h0);
    endtask

    task noprog(input logic [1:0] sp, input logic [3:0] k1, input logic [3:0] k2, input logic [3:0] k3);
        key(sp, k1);
        key(sp, k2);
        key(sp, k3);
        repeat (3) @(posedge clock);
        cmp(core_idle, 32'h0);
    endtask

    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            cmp(avs_readdata, rq.pop_front());
        end
        if (rd_valid === 1'b1) begin
            cmp(rd_data, cq.pop_front());
        end
    end

    initial begin
        #20000;
        cmp(32'h0, 32'h1);
        conclude;
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        fuse <= 1'b0;
        rd(flash_seq_pkg::AUX_IDX, 8'h20);
        rd(8'h10, 8'h00);
        bus(1'b1, flash_seq_pkg::AUX_IDX, 8'h0D);
        rd(flash_seq_pkg::AUX_IDX, 8'h09);
        p0 = $random(seed);
        p1 = $random(seed);
        bus(1'b1, flash_seq_pkg::DP0_LO_IDX, p0[7:0]);
        bus(1'b1, flash_seq_pkg::DP0_HI_IDX, p0[15:8]);
        bus(1'b1, flash_seq_pkg::DP1_LO_IDX, p1[7:0]);
        bus(1'b1, flash_seq_pkg::DP1_HI_IDX, p1[15:8]);
        repeat (2) @(posedge clock);
        cmp(active_dptr, p1);
        bus(1'b1, flash_seq_pkg::AUX_IDX, 8'h08);
        repeat (2) @(posedge clock);
        cmp(active_dptr, p0);
        $display("test auxiliary register done");
        bus(1'b1, flash_seq_pkg::IRQ_MASK_IDX, 8'h01);
        d1 = $random(seed);
        d2 = $random(seed);
        prog(flash_seq_pkg::SPACE_USER, 16'h0010, d1);
        cf(16'h0010, 1'b0, d1);
        prog(flash_seq_pkg::SPACE_USER, 16'hF900, d2);
        bus(1'b1, flash_seq_pkg::AUX_IDX, 8'h20);
        prog(flash_seq_pkg::SPACE_USER, 16'hF900, ~d2);
        cf(16'hF900, 1'b0, ~d2);
        bus(1'b1, flash_seq_pkg::AUX_IDX, 8'h00);
        cf(16'hF900, 1'b0, d2);
        $display("test user and boot programming done");
        prog(flash_seq_pkg::SPACE_EXTRA, 16'hFF85, ~d1);
        cf(16'hFF85, 1'b1, ~d1);
        cf(16'h0010, 1'b1, 8'hFF);
        prog(flash_seq_pkg::SPACE_SECURITY, 16'h0000, d2);
        cf(16'h0000, 1'b1, d2);
        cf(16'h0001, 1'b1, 8'hFF);
        cf(16'h0010, 1'b0, d1);
        $display("test extra row and security done");
        noprog(flash_seq_pkg::SPACE_USER, flash_seq_pkg::KEY_ARM, 4'h3, flash_seq_pkg::KEY_LAUNCH);
        rd(flash_seq_pkg::IRQ_STS_IDX, 8'h02);
        cmp(irq, 32'h0);
        bus(1'b1, flash_seq_pkg::IRQ_STS_IDX, 8'h02);
        noprog(flash_seq_pkg::SPACE_RESERVED, 4'h0, flash_seq_pkg::KEY_ARM, flash_seq_pkg::KEY_LAUNCH);
        cf(16'h0000, 1'b1, 8'hFF);
        noprog(flash_seq_pkg::SPACE_USER, 4'h0, 4'h0, flash_seq_pkg::KEY_ARM);
        $display("test refused launches done");
        conclude;
    end
endmodule
`default_nettype wire
